// >>> core/cel_pkg.sv
// Shared constants, codes and carrier types of the cache error log record.
package cel_pkg;

  // Clock rate of sys_clk_i
  localparam int unsigned CLK_HZ = 50_000_000;

  // Printed field offsets are register indices; byte address is four times the index
  localparam logic [11:0] IDX_VALID    = 12'h000;
  localparam logic [11:0] IDX_LENGTH   = 12'h004;
  localparam logic [11:0] IDX_KIND     = 12'h006;
  localparam logic [11:0] IDX_OPER     = 12'h007;
  localparam logic [11:0] IDX_ERROR    = 12'h008;
  localparam logic [11:0] IDX_LEVEL    = 12'h009;
  localparam logic [11:0] IDX_SET      = 12'h00A;
  localparam logic [11:0] IDX_WAY      = 12'h00E;
  localparam logic [11:0] IDX_INSTANCE = 12'h012;
  localparam logic [11:0] IDX_PAD      = 12'h013;
  localparam logic [11:0] IDX_VENDOR   = 12'h014;

  // Block-local control registers and the vendor window
  localparam logic [11:0] ADDR_STATUS   = 12'h080;
  localparam logic [11:0] ADDR_MASK     = 12'h084;
  localparam logic [11:0] ADDR_LOGPOS   = 12'h088;
  localparam logic [11:0] ADDR_VEN_BASE = 12'h100;

  // Record geometry
  localparam logic [15:0] REC_FIXED_LEN   = 16'h0014;
  localparam logic [7:0]  LOG_RECORD_DW   = 8'h05;
  localparam logic [15:0] LOG_RECORD_BYTE = 16'h0014;
  localparam int unsigned VEN_WORDS_DEF   = 16;

  // Validity bit positions
  localparam int unsigned VB_KIND     = 0;
  localparam int unsigned VB_OPER     = 1;
  localparam int unsigned VB_ERROR    = 2;
  localparam int unsigned VB_LEVEL    = 3;
  localparam int unsigned VB_SET      = 4;
  localparam int unsigned VB_WAY      = 5;
  localparam int unsigned VB_INSTANCE = 6;
  localparam int unsigned VB_VENDOR   = 7;
  localparam int unsigned VB_COUNT    = 8;

  // Status and mask bit positions, reset values
  localparam int unsigned ST_NEW     = 0;
  localparam int unsigned ST_OVERRUN = 1;
  localparam int unsigned ST_W       = 2;
  localparam logic [1:0]  ST_RESET   = 2'h0;
  localparam logic [1:0]  MASK_RESET = 2'h0;

  // Cache kinds
  typedef enum logic [7:0] {
    CK_INSTR    = 8'h00,
    CK_DATA     = 8'h01,
    CK_UNIFIED  = 8'h02,
    CK_SNOOPDIR = 8'h03
  } cel_cache_kind_e;

  // Failing operations
  typedef enum logic [7:0] {
    OP_GENERIC  = 8'h00,
    OP_GEN_RD   = 8'h01,
    OP_GEN_WR   = 8'h02,
    OP_DATA_RD  = 8'h03,
    OP_DATA_WR  = 8'h04,
    OP_IFETCH   = 8'h05,
    OP_PREFETCH = 8'h06,
    OP_EVICT    = 8'h07,
    OP_SNOOPING = 8'h08,
    OP_SNOOPED  = 8'h09,
    OP_MGMT     = 8'h0A
  } cel_oper_e;

  // Error kinds
  typedef enum logic [7:0] {
    EK_DATA     = 8'h00,
    EK_TAG      = 8'h01,
    EK_TIMEOUT  = 8'h02,
    EK_HANG     = 8'h03,
    EK_LOST     = 8'h04,
    EK_BAD_ADDR = 8'h05
  } cel_err_kind_e;

  // Fixed fields of one record
  typedef struct packed {
    logic [7:0]  cache_kind;
    logic [7:0]  failing_operation;
    logic [7:0]  error_kind;
    logic [7:0]  hierarchy_level;
    logic [31:0] set_index;
    logic [31:0] way_number;
    logic [7:0]  cache_instance;
  } cel_rec_s;

  // One error report from the cache logic
  typedef struct packed {
    cel_rec_s    rec;
    logic [6:0]  present;
    logic [15:0] vendor_info_length;
  } cel_report_s;

endpackage : cel_pkg

// >>> core/cel_ven_buf.sv
// Word store for vendor-specific trailing information.
`timescale 1ns/1ps
module cel_ven_buf #(
  parameter int unsigned WORDS = 16,
  parameter int unsigned IW    = 4
) (
  // Clock
  input  wire logic          clk_i,
  // Write side
  input  wire logic          wr_en_i,
  input  wire logic [IW-1:0] wr_idx_i,
  input  wire logic [31:0]   wr_data_i,
  // Read side
  input  wire logic [IW-1:0] rd_idx_i,
  output logic      [31:0]   rd_data_o
);

  logic [31:0] mem [WORDS];

  // No reset on the array; contents matter only below the reported length
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_idx_i];

endmodule : cel_ven_buf

// >>> core/cel_record_top.sv
// Cache error log record: capture of error reports and APB read-out.
`timescale 1ns/1ps
module cel_record_top #(
  parameter int unsigned VEN_WORDS = cel_pkg::VEN_WORDS_DEF,
  parameter int unsigned VIW       = $clog2(VEN_WORDS)
) (
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // APB slave
  input  wire logic [11:0]         paddr_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Error reports from the cache logic
  input  wire logic                report_valid_i,
  input  wire cel_pkg::cel_report_s report_i,
  // Vendor information words
  input  wire logic                ven_wr_i,
  input  wire logic [VIW-1:0]      ven_idx_i,
  input  wire logic [31:0]         ven_data_i,
  // Interrupt
  output logic                     irq_o
);

  typedef enum logic [1:0] {
    CEL_APB_IDLE   = 2'b00,
    CEL_APB_ANSWER = 2'b01
  } cel_apb_e;

  localparam logic [15:0] VEN_MAX   = 16'(VEN_WORDS * 4);
  localparam logic [11:0] VEN_LIMIT = 12'(cel_pkg::ADDR_VEN_BASE + 12'(VEN_WORDS * 4));

  // Byte address of a register from its printed index
  function automatic logic [11:0] idx_addr(input logic [11:0] idx);
    idx_addr = {idx[9:0], 2'b00};
  endfunction : idx_addr

  // Word hit of a bus address on a target
  function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] target);
    word_hit = (addr[11:2] == target[11:2]);
  endfunction : word_hit

  // Record state
  cel_pkg::cel_rec_s           rec_r;
  logic [cel_pkg::VB_COUNT-1:0] valid_r;
  logic [cel_pkg::VB_COUNT-1:0] valid_nxt;
  logic [15:0]                 len_r;
  logic [15:0]                 ven_len_clip;

  // Control state
  logic [cel_pkg::ST_W-1:0]    status_r;
  logic [cel_pkg::ST_W-1:0]    status_nxt;
  logic [cel_pkg::ST_W-1:0]    status_set;
  logic [cel_pkg::ST_W-1:0]    status_clr;
  logic [cel_pkg::ST_W-1:0]    mask_r;
  logic                        irq_r;

  // Bus state
  cel_apb_e                    apb_st_r;
  logic [31:0]                 prdata_r;
  logic                        pready_r;
  logic                        pslverr_r;
  logic [31:0]                 rd_data;
  logic                        rd_hit;
  logic                        wr_commit;
  logic                        ven_hit;
  logic [VIW-1:0]              ven_rd_idx;
  logic [31:0]                 ven_rd_data;

  cel_ven_buf #(
    .WORDS (VEN_WORDS),
    .IW    (VIW)
  ) u_ven_buf (
    .clk_i     (sys_clk_i),
    .wr_en_i   (ven_wr_i),
    .wr_idx_i  (ven_idx_i),
    .wr_data_i (ven_data_i),
    .rd_idx_i  (ven_rd_idx),
    .rd_data_o (ven_rd_data)
  );

  // Vendor data larger than the store is cut, so the length never promises missing bytes
  always_comb begin
    if (report_i.vendor_info_length > VEN_MAX) begin
      ven_len_clip = VEN_MAX;
    end else begin
      ven_len_clip = report_i.vendor_info_length;
    end
  end

  // A field carrying a reserved code is stored but left flagged invalid
  always_comb begin
    valid_nxt = '0;
    valid_nxt[cel_pkg::VB_KIND] = report_i.present[cel_pkg::VB_KIND] &&
                                 (report_i.rec.cache_kind <= cel_pkg::CK_SNOOPDIR);
    valid_nxt[cel_pkg::VB_OPER] = report_i.present[cel_pkg::VB_OPER] &&
                                 (report_i.rec.failing_operation <= cel_pkg::OP_MGMT);
    valid_nxt[cel_pkg::VB_ERROR] = report_i.present[cel_pkg::VB_ERROR] &&
                                  (report_i.rec.error_kind <= cel_pkg::EK_BAD_ADDR);
    valid_nxt[cel_pkg::VB_LEVEL] = report_i.present[cel_pkg::VB_LEVEL];
    valid_nxt[cel_pkg::VB_SET] = report_i.present[cel_pkg::VB_SET];
    valid_nxt[cel_pkg::VB_WAY] = report_i.present[cel_pkg::VB_WAY];
    valid_nxt[cel_pkg::VB_INSTANCE] = report_i.present[cel_pkg::VB_INSTANCE];
    valid_nxt[cel_pkg::VB_VENDOR] = (ven_len_clip != 16'h0000);
  end

  // Fields, flags and length move in the same edge, so no reader sees a torn record
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_r   <= '0;
      valid_r <= '0;
      len_r   <= cel_pkg::REC_FIXED_LEN;
    end else if (report_valid_i) begin
      rec_r   <= report_i.rec;
      valid_r <= valid_nxt;
      len_r   <= 16'(cel_pkg::REC_FIXED_LEN + ven_len_clip);
    end
  end

  // Register read decode
  always_comb begin
    rd_hit     = 1'b1;
    rd_data    = 32'h0000_0000;
    ven_hit    = (paddr_i >= cel_pkg::ADDR_VEN_BASE) && (paddr_i < VEN_LIMIT);
    ven_rd_idx = paddr_i[VIW+1:2];
    if (ven_hit) begin
      rd_data = ven_rd_data;
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_VALID))) begin
      rd_data = {24'h00_0000, valid_r};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_LENGTH))) begin
      rd_data = {16'h0000, len_r};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_KIND))) begin
      rd_data = {24'h00_0000, rec_r.cache_kind};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_OPER))) begin
      rd_data = {24'h00_0000, rec_r.failing_operation};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_ERROR))) begin
      rd_data = {24'h00_0000, rec_r.error_kind};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_LEVEL))) begin
      rd_data = {24'h00_0000, rec_r.hierarchy_level};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_SET))) begin
      rd_data = rec_r.set_index;
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_WAY))) begin
      rd_data = rec_r.way_number;
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_INSTANCE))) begin
      rd_data = {24'h00_0000, rec_r.cache_instance};
    end else if (word_hit(paddr_i, idx_addr(cel_pkg::IDX_PAD))) begin
      rd_data = 32'h0000_0000;
    end else if (word_hit(paddr_i, cel_pkg::ADDR_STATUS)) begin
      rd_data = {30'h0000_0000, status_r};
    end else if (word_hit(paddr_i, cel_pkg::ADDR_MASK)) begin
      rd_data = {30'h0000_0000, mask_r};
    end else if (word_hit(paddr_i, cel_pkg::ADDR_LOGPOS)) begin
      rd_data = {8'h00, cel_pkg::LOG_RECORD_DW, cel_pkg::LOG_RECORD_BYTE};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state: decode in the first access cycle, answer in the second
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      apb_st_r  <= CEL_APB_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      case (apb_st_r)
        CEL_APB_IDLE: begin
          if (psel_i && penable_i) begin
            apb_st_r  <= CEL_APB_ANSWER;
            pready_r  <= 1'b1;
            pslverr_r <= ~rd_hit;
            prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_data;
          end
        end
        CEL_APB_ANSWER: begin
          apb_st_r  <= CEL_APB_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r  <= 32'h0000_0000;
        end
        default: begin
          apb_st_r  <= CEL_APB_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r  <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Writes land on the edge where the master sees pready; record fields ignore writes
  assign wr_commit = (apb_st_r == CEL_APB_ANSWER) && psel_i && penable_i && pwrite_i;

  // Interrupt events: new record, and a record replaced before software acknowledged it
  always_comb begin
    status_set = '0;
    status_clr = '0;
    status_set[cel_pkg::ST_NEW]     = report_valid_i;
    status_set[cel_pkg::ST_OVERRUN] = report_valid_i && status_r[cel_pkg::ST_NEW];
    if (wr_commit && word_hit(paddr_i, cel_pkg::ADDR_STATUS)) begin
      status_clr = pwdata_i[cel_pkg::ST_W-1:0];
    end
    // Set beats clear so an event in the clearing cycle survives
    status_nxt = (status_r & ~status_clr) | status_set;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= cel_pkg::ST_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_r <= cel_pkg::MASK_RESET;
    end else if (wr_commit && word_hit(paddr_i, cel_pkg::ADDR_MASK)) begin
      mask_r <= pwdata_i[cel_pkg::ST_W-1:0];
    end
  end

  // Registered, so the line trails the status bit by one cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o     = irq_r;

endmodule : cel_record_top

// >>> verification/cel_record_checker.sv
// Port checker of the cache error log record.
`timescale 1ns/1ps
module cel_record_checker #(
  parameter int unsigned VEN_WORDS = 16,
  parameter int unsigned VIW       = 4
) (
  // Clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  // APB
  input wire logic [11:0]          paddr_i,
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic                 pwrite_i,
  input wire logic [31:0]          pwdata_i,
  input wire logic [31:0]          prdata_o,
  input wire logic                 pready_o,
  input wire logic                 pslverr_o,
  // Reports and vendor words
  input wire logic                 report_valid_i,
  input wire cel_pkg::cel_report_s report_i,
  input wire logic                 ven_wr_i,
  input wire logic [VIW-1:0]       ven_idx_i,
  input wire logic [31:0]          ven_data_i,
  // Interrupt
  input wire logic                 irq_o
);
  cel_pkg::cel_rec_s rec_r;
  logic [31:0]       vld_r;
  logic [15:0]       len_r;
  logic [31:0]       fld;
  logic              hit;
  wire logic         rd = pready_o && !pwrite_i;

  // Shadow of the last report, as software should see it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_r <= '0;
      vld_r <= '0;
      len_r <= 16'h0014;
    end else if (report_valid_i) begin
      rec_r <= report_i.rec;
      vld_r <= {24'h0, report_i.vendor_info_length != 16'h0, report_i.present & {4'hF,
                report_i.rec.error_kind <= 8'h05, report_i.rec.failing_operation <= 8'h0A,
                report_i.rec.cache_kind <= 8'h03}};
      len_r <= (report_i.vendor_info_length > 16'(VEN_WORDS*4)) ? 16'(20 + VEN_WORDS*4) :
               16'h0014 + report_i.vendor_info_length;
    end
  end

  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      12'h018: fld = {24'h0, rec_r.cache_kind};
      12'h01C: fld = {24'h0, rec_r.failing_operation};
      12'h020: fld = {24'h0, rec_r.error_kind};
      12'h024: fld = {24'h0, rec_r.hierarchy_level};
      12'h028: fld = rec_r.set_index;
      12'h038: fld = rec_r.way_number;
      12'h048: fld = {24'h0, rec_r.cache_instance};
      default: begin
        hit = 1'b0;
        fld = '0;
      end
    endcase
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  valid_word_a :
    assert property (rd && paddr_i == 12'h000 && !$past(report_valid_i) |-> prdata_o == vld_r) else $error("valid word");
  valid_rsvd_a :
    assert property (rd && paddr_i == 12'h000 |-> prdata_o[31:8] == 24'h0 && !pslverr_o) else $error("reserved bits");
  length_a :
    assert property (rd && paddr_i == 12'h010 && !$past(report_valid_i) |-> prdata_o == {16'h0, len_r})
      else $error("record length");
  field_a :
    assert property (rd && hit && !$past(report_valid_i) |-> prdata_o == fld) else $error("record field");
  pad_zero_a :
    assert property (rd && paddr_i == 12'h04C |-> prdata_o == 32'h0) else $error("pad byte");
  log_pos_a :
    assert property (rd && paddr_i == 12'h088 |-> prdata_o == 32'h0005_0014) else $error("log position");
  answer_next_a :
    assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no answer");
  ready_pulse_a :
    assert property (pready_o |=> !pready_o) else $error("ready too long");
  unmapped_a :
    assert property (pready_o && paddr_i == 12'h0FC |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped");

  cover property (rd && paddr_i == 12'h000 && prdata_o[7]);
  cover property (pslverr_o);
  cover property ($rose(irq_o));
  cover property (rd && paddr_i == 12'h01C && prdata_o == 32'h0000_0009);
endmodule : cel_record_checker

bind cel_record_top cel_record_checker #(.VEN_WORDS(VEN_WORDS), .VIW(VIW)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .report_valid_i(report_valid_i), .report_i(report_i), .ven_wr_i(ven_wr_i), .ven_idx_i(ven_idx_i),
  .ven_data_i(ven_data_i), .irq_o(irq_o));

// >>> verification/tb_top.sv
// Self-checking testbench of the cache error log record.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {cel_pkg::cel_report_s r; logic [31:0] v; logic [15:0] l;} cel_row_s;
  logic                 sys_clk_i = 1'b0;
  logic                 rst_i     = 1'b1;
  logic [11:0]          paddr     = '0;
  logic                 psel      = 1'b0;
  logic                 penable   = 1'b0;
  logic                 pwrite    = 1'b0;
  logic [31:0]          pwdata    = '0;
  logic                 rep_vld   = 1'b0;
  cel_pkg::cel_report_s rep       = '0;
  logic                 ven_wr    = 1'b0;
  logic [3:0]           ven_idx   = '0;
  logic [31:0]          ven_data  = '0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  logic [31:0]          rd;
  logic                 er;
  int                   err_count = 0;
  int                   checked   = 0;
  cel_row_s             rows [4];
  logic [31:0]          fe [10];
  logic [11:0]          fa [10] = '{12'h000, 12'h010, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028, 12'h038,
                                    12'h048, 12'h04C};

  always #10 sys_clk_i = ~sys_clk_i;

  cel_record_top DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .report_valid_i(rep_vld), .report_i(rep), .ven_wr_i(ven_wr), .ven_idx_i(ven_idx),
    .ven_data_i(ven_data), .irq_o(irq));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high, released at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask : rc

  task automatic send(input cel_pkg::cel_report_s r);
    @(posedge sys_clk_i);
    rep     <= r;
    rep_vld <= 1'b1;
    @(posedge sys_clk_i);
    rep_vld <= 1'b0;
  endtask : send

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    rows[0] = '{'{'{8'h01, 8'h08, 8'h01, 8'h02, 32'h0000_1234, 32'h3, 8'h05}, 7'h7F, 16'h0}, 32'h7F, 16'h0014};
    rows[1] = '{'{'{8'h03, 8'h09, 8'h05, 8'h01, 32'hFFFF_FFFF, 32'h0, 8'h00}, 7'h15, 16'h8}, 32'h95, 16'h001C};
    rows[2] = '{'{'{8'h00, 8'h0A, 8'h03, 8'h07, 32'h0, 32'hF, 8'h0F}, 7'h00, 16'h00C8}, 32'h80, 16'h0054};
    rows[3] = '{'{'{8'h02, 8'h04, 8'h04, 8'hFF, 32'h8000_0001, 32'h7, 8'hFF}, 7'h7F, 16'h1}, 32'hFF, 16'h0015};
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      ven_wr   <= 1'b1;
      ven_idx  <= 4'(k);
      ven_data <= 32'hA5A5_0000 + 32'(k);
    end
    @(posedge sys_clk_i);
    ven_wr <= 1'b0;
    for (int k = 0; k < 4; k++) rc(12'h100 + 12'(4 * k), 32'hA5A5_0000 + 32'(k), "vendor word");
    foreach (rows[n]) begin
      send(rows[n].r);
      fe = '{rows[n].v, {16'h0, rows[n].l}, {24'h0, rows[n].r.rec.cache_kind}, {24'h0, rows[n].r.rec.failing_operation},
             {24'h0, rows[n].r.rec.error_kind}, {24'h0, rows[n].r.rec.hierarchy_level}, rows[n].r.rec.set_index,
             rows[n].r.rec.way_number, {24'h0, rows[n].r.rec.cache_instance}, 32'h0};
      for (int j = 0; j < 10; j++) chk_row(j);
    end
    $display("test record rows finished");
    // Reserved codes keep the field but drop its validity
    for (int i = 0; i < 12; i++) begin
      send('{'{8'(i), 8'(i), 8'(i), 8'h01, 32'h0, 32'h0, 8'h0}, 7'h7F, 16'h0});
      rc(12'h000, {25'h0, 4'hF, i < 6, i < 11, i < 4}, "code validity");
    end
    $display("test codes finished");
    rc(12'h080, 32'h3, "status new and overrun");
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, 12'h084, 32'h1);
    rc(12'h084, 32'h1, "mask readback");
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, 12'h080, 32'h1);
    rc(12'h080, 32'h2, "status cleared bit");
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    send('{'{8'h02, 8'h07, 8'h00, 8'h03, 32'h0, 32'h0, 8'h0}, 7'h7F, 16'h0});
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq}, 32'h1, "irq on report");
    // Clear and new report on the same edge: the new record must stay flagged
    fork
      apb(1'b1, 12'h080, 32'h1);
      begin
        repeat (3) @(posedge sys_clk_i);
        rep_vld <= 1'b1;
        @(posedge sys_clk_i);
        rep_vld <= 1'b0;
      end
    join
    rc(12'h080, 32'h3, "set beats clear");
    $display("test interrupt finished");
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    rc(12'h018, 32'h2, "read-only field");
    rc(12'h088, 32'h0005_0014, "log position");
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test access finished");
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rc(12'h000, 32'h0, "valid after reset");
    rc(12'h010, 32'h0000_0014, "length after reset");
    rc(12'h080, 32'h0, "status after reset");
    rc(12'h084, 32'h0, "mask after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test reset finished");
    end_sim();
  end

  task automatic chk_row(input int j);
    rc(fa[j], fe[j], "record field");
  endtask : chk_row
endmodule : tb_top
